// >>> src/spil_top.v
// serial port pins, start detect and interrupt combining
`timescale 1ns/1ps
`include "spil_defs.vh"

// Functional notes
// - bus pins are never driven unless the enable bit is one
// - enabled and control bit zero pulls that pin low
// - reads return live clock and data pin levels
// - released bus: data falling with clock high is a start
// - start with its enable set sets flag and requests interrupt
// - with the enable bit one, stretch enable holds clock low while start flag pending
// - alt strap low at reset: port strap picks one of two addresses
// - interrupt pin low only with global enable set, any mode
// - VGA mode: retrace only, disable zero and armed bit one
// - writing arm bit zero clears retrace interrupt; write one re-arms
// - enhanced mode: eight sources, each enabled, cleared, with status
// - pin stays asserted until every status bit is cleared
module spil_top (
    // clock and reset
    input wire clock,
    input wire rstn,
    // register access port
    input wire acc_io,
    input wire [7:0] acc_addr,
    input wire acc_wr,
    input wire acc_rd,
    input wire [31:0] acc_wdata,
    output reg [31:0] acc_rdata,
    // serial clock pin
    input wire serial_clock_pin_i,
    output reg serial_clock_pin_o,
    output reg serial_clock_pin_oe_n,
    // serial data pin
    input wire serial_data_pin_i,
    output reg serial_data_pin_o,
    output reg serial_data_pin_oe_n,
    // reset straps
    input wire port_address_strap,
    input wire alt_port_enable_strap,
    // interrupt event pulses
    input wire vretrace_evt,
    input wire [6:0] engine_evt,
    // interrupt pin, active low
    output reg interrupt_pin_n
);
    // register state
    reg [31:0] spc_r;
    reg [31:0] vic_r;
    reg [7:0] gie_r;
    reg [7:0] rtc_r;
    reg [7:0] opm_r;
    reg alt_en_r;
    reg alt_hi_r;
    reg vga_pend_r;
    reg sda_prev_r;
    reg [31:0] rd_nxt;
    wire [3:0] pins_s;
    wire scl_s;
    wire sda_s;
    wire strap_port_s;
    wire strap_alt_s;
    wire [7:0] eis_status;
    wire [7:0] eis_enable;
    wire eis_any;
    wire io_hit;
    wire spc_sel;
    wire vic_wr;
    wire rtc_wr;
    wire start_seen;
    wire start_flag_nxt;
    wire drive_clk;
    wire drive_dat;
    wire irq_nxt;
    wire vga_pend_nxt;
    // per-register selects and strobes
    wire spc_wr;
    wire gie_wr;
    wire opm_wr;
    wire eis_wr;
    wire vic_sel;
    wire gie_sel;
    wire rtc_sel;
    wire opm_sel;
    wire eis_sel;
    // clock drive and interrupt terms
    wire clk_sw_low;
    wire clk_stretch;
    wire vga_irq;
    wire mode_irq;

    // memory-space decode of one register offset
    // an I/O cycle never hits a memory offset
    function mem_hit;
        input io;
        input [7:0] addr;
        input [7:0] ofs;
        begin
            mem_hit = !io && (addr == ofs);
        end
    endfunction

    // pins and straps come from outside the clock domain; the chain is
    // not reset so that straps reach the capture flops while reset holds
    spil_sync u_sync (
        .clock(clock),
        .async_in({alt_port_enable_strap, port_address_strap,
            serial_data_pin_i, serial_clock_pin_i}),
        .sync_out(pins_s)
    );
    assign scl_s = pins_s[0];
    assign sda_s = pins_s[1];
    assign strap_port_s = pins_s[2];
    assign strap_alt_s = pins_s[3];

    assign io_hit = acc_io && alt_en_r && (acc_addr ==
        (alt_hi_r ? `SPIL_IO_PORT_HI : `SPIL_IO_PORT_LO));
    assign spc_sel = io_hit || mem_hit(acc_io, acc_addr, `SPIL_OFS_SPC);
    assign vic_wr = acc_wr && mem_hit(acc_io, acc_addr, `SPIL_OFS_VIC);
    assign rtc_wr = acc_wr && mem_hit(acc_io, acc_addr, `SPIL_OFS_RTC);

    // one select per register keeps read mux and write paths in step
    assign vic_sel = mem_hit(acc_io, acc_addr, `SPIL_OFS_VIC);
    assign gie_sel = mem_hit(acc_io, acc_addr, `SPIL_OFS_GIE);
    assign rtc_sel = mem_hit(acc_io, acc_addr, `SPIL_OFS_RTC);
    assign opm_sel = mem_hit(acc_io, acc_addr, `SPIL_OFS_OPM);
    assign eis_sel = mem_hit(acc_io, acc_addr, `SPIL_OFS_EIS);

    // write strobes; the serial register answers on either port
    assign spc_wr = acc_wr && spc_sel;
    assign gie_wr = acc_wr && gie_sel;
    assign opm_wr = acc_wr && opm_sel;
    assign eis_wr = acc_wr && eis_sel;

    // falling data with clock high, bus released by us
    // an edge, not a level, so a data line held low counts once
    assign start_seen = !drive_dat && !drive_clk && scl_s
        && sda_prev_r && !sda_s;

    // flag set only when enabled; set beats a software clear
    assign start_flag_nxt = (start_seen && vic_r[`SPIL_VIC_START_IE])
        || (vic_r[`SPIL_VIC_START_FLAG]
        && !(vic_wr && acc_wdata[`SPIL_VIC_START_FLAG]));

    // drive only when enabled; control bit zero pulls low
    assign drive_dat = spc_r[`SPIL_SPC_EN] && !spc_r[`SPIL_SPC_DAT];
    // software asks for the clock low
    assign clk_sw_low = !spc_r[`SPIL_SPC_CLK];
    // clock stretch while the start flag is pending
    assign clk_stretch = vic_r[`SPIL_VIC_STRETCH]
        && vic_r[`SPIL_VIC_START_FLAG];
    // stretch also needs the enable bit: a disabled port must
    // never touch the bus, at the cost of no wait states while off
    assign drive_clk = spc_r[`SPIL_SPC_EN] && (clk_sw_low || clk_stretch);

    // retrace latches only when armed and not disabled
    // writing the arm bit to zero clears the pending retrace
    assign vga_pend_nxt = rtc_r[`SPIL_RTC_ARM] && !(rtc_wr
        && !acc_wdata[`SPIL_RTC_ARM]) && (vga_pend_r
        || (vretrace_evt && !rtc_r[`SPIL_RTC_DIS]));

    // a set disable bit masks a retrace that is still pending
    assign vga_irq = vga_pend_r && !rtc_r[`SPIL_RTC_DIS];
    // mode picks VGA retrace or the enhanced sources
    assign mode_irq = opm_r[`SPIL_OPM_ENH] ? eis_any : vga_irq;
    // gate every source with the global enable
    assign irq_nxt = gie_r[`SPIL_GIE_BIT]
        && (vic_r[`SPIL_VIC_START_FLAG] || mode_irq);

    // enhanced sources: retrace plus seven engine events
    spil_enh u_enh (
        .clock(clock),
        .rstn(rstn),
        .evt({engine_evt, vretrace_evt}),
        .wr(eis_wr),
        .wdata(acc_wdata[15:0]),
        .status_r(eis_status),
        .enable_r(eis_enable),
        .any_r(eis_any)
    );

    // read mux, unmapped offsets read zero
    // live pin bits bypass the register so a read sees the bus itself
    always @* begin
        rd_nxt = 32'h0000_0000;
        if (spc_sel) begin
            rd_nxt = spc_r;
            rd_nxt[`SPIL_SPC_CLK_IN] = scl_s;
            rd_nxt[`SPIL_SPC_DAT_IN] = sda_s;
        end else if (vic_sel) begin
            rd_nxt = vic_r;
        end else if (gie_sel) begin
            rd_nxt = {24'h00_0000, gie_r};
        end else if (rtc_sel) begin
            rd_nxt = {24'h00_0000, rtc_r};
        end else if (opm_sel) begin
            rd_nxt = {24'h00_0000, opm_r};
        end else if (eis_sel) begin
            rd_nxt = {16'h0000, eis_enable, eis_status};
        end
    end

    // straps caught on every edge while reset is held; reset must last
    // three cycles or more to clear the synchroniser, and a strap that
    // moves after release is ignored until the next reset
    always @(posedge clock) begin
        if (!rstn) begin
            // alternate port only with alt strap low
            alt_en_r <= !strap_alt_s;
            alt_hi_r <= strap_port_s;
        end
    end

    // start edge history and retrace pending state
    always @(posedge clock) begin
        if (!rstn) begin
            vga_pend_r <= 1'b0;
            sda_prev_r <= 1'b1;
        end else begin
            sda_prev_r <= sda_s;
            vga_pend_r <= vga_pend_nxt;
        end
    end

    // read data loads on the read strobe and stands until the next read
    always @(posedge clock) begin
        if (!rstn) begin
            acc_rdata <= 32'h0000_0000;
        end else if (acc_rd) begin
            acc_rdata <= rd_nxt;
        end
    end

    // serial port register; its status bits are read only
    always @(posedge clock) begin
        if (!rstn) begin
            spc_r <= `SPIL_SPC_RST;
        end else if (spc_wr) begin
            spc_r <= {27'h000_0000, acc_wdata[`SPIL_SPC_EN],
                2'b00, acc_wdata[1:0]};
        end
    end

    // video interrupt control: writes reach the two enables only, the
    // flag follows its own set and clear term so a write cannot set it
    always @(posedge clock) begin
        if (!rstn) begin
            vic_r <= `SPIL_VIC_RST;
        end else begin
            if (vic_wr) begin
                vic_r <= acc_wdata & `SPIL_VIC_WMASK;
            end
            vic_r[`SPIL_VIC_START_FLAG] <= start_flag_nxt;
        end
    end

    // byte-wide control registers
    always @(posedge clock) begin
        if (!rstn) begin
            gie_r <= `SPIL_CTL8_RST;
            rtc_r <= `SPIL_CTL8_RST;
            opm_r <= `SPIL_CTL8_RST;
        end else begin
            if (gie_wr) begin
                gie_r <= acc_wdata[7:0];
            end
            if (rtc_wr) begin
                rtc_r <= acc_wdata[7:0];
            end
            if (opm_wr) begin
                opm_r <= acc_wdata[7:0];
            end
        end
    end

    // pin drivers, all registered; the pin value is fixed low and only
    // the enable moves, so a released pin never glitches high
    always @(posedge clock) begin
        if (!rstn) begin
            serial_clock_pin_o <= 1'b0;
            serial_data_pin_o <= 1'b0;
            serial_clock_pin_oe_n <= 1'b1;
            serial_data_pin_oe_n <= 1'b1;
        end else begin
            serial_clock_pin_o <= 1'b0;
            serial_data_pin_o <= 1'b0;
            // released pin lets pull-ups set the level
            serial_clock_pin_oe_n <= !drive_clk;
            serial_data_pin_oe_n <= !drive_dat;
        end
    end

    always @(posedge clock) begin
        if (!rstn) begin
            interrupt_pin_n <= 1'b1;
        end else begin
            interrupt_pin_n <= !irq_nxt;
        end
    end
endmodule

// >>> src/spil_defs.vh
// constants for the serial port and interrupt logic
`ifndef SPIL_DEFS_VH
`define SPIL_DEFS_VH

// register offsets on the access port (memory-space cycles)
`define SPIL_OFS_VIC 8'h08
`define SPIL_OFS_SPC 8'h20
`define SPIL_OFS_GIE 8'h32
`define SPIL_OFS_RTC 8'h11
`define SPIL_OFS_OPM 8'h66
`define SPIL_OFS_EIS 8'h84

// alternate I/O port addresses of the serial port register
`define SPIL_IO_PORT_HI 8'he2
`define SPIL_IO_PORT_LO 8'he8

// serial port register fields
`define SPIL_SPC_CLK 0
`define SPIL_SPC_DAT 1
`define SPIL_SPC_CLK_IN 2
`define SPIL_SPC_DAT_IN 3
`define SPIL_SPC_EN 4

// video interrupt control fields
`define SPIL_VIC_START_FLAG 3
`define SPIL_VIC_START_IE 19
`define SPIL_VIC_STRETCH 24
// writable enables of the video interrupt control word
`define SPIL_VIC_WMASK 32'h0108_0000

// global enable, retrace control and mode fields
`define SPIL_GIE_BIT 4
`define SPIL_RTC_ARM 4
`define SPIL_RTC_DIS 5
`define SPIL_OPM_ENH 0

// enhanced status: status in 7:0, enables in 15:8
`define SPIL_EIS_NSRC 8
`define SPIL_EIS_EN_LSB 8

// reset values
`define SPIL_SPC_RST 32'h0000_0003
`define SPIL_VIC_RST 32'h0000_0000
`define SPIL_CTL8_RST 8'h00

`endif

// >>> src/spil_sync.v
// two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module spil_sync (
    // clock
    input wire clock,
    // asynchronous levels in, synchronised levels out
    input wire [3:0] async_in,
    output reg [3:0] sync_out
);
    reg [3:0] meta_r;

    // first stage feeds only the second; no reset, so a strap level
    // passes through while the rest of the block is held in reset
    always @(posedge clock) begin
        meta_r <= async_in;
        sync_out <= meta_r;
    end
endmodule

// >>> src/spil_enh.v
// enhanced-mode interrupt sources: status, enables, clears
`timescale 1ns/1ps
`include "spil_defs.vh"
module spil_enh (
    // clock and reset
    input wire clock,
    input wire rstn,
    // source event pulses, one bit per source
    input wire [7:0] evt,
    // register write
    input wire wr,
    input wire [15:0] wdata,
    // state
    output reg [7:0] status_r,
    output reg [7:0] enable_r,
    output reg any_r
);
    wire [7:0] status_nxt;

    // set beats clear; only enabled sources latch
    assign status_nxt = (status_r & ~(wr ? wdata[7:0] : 8'h00))
        | (evt & enable_r);

    // write one to a status bit clears it
    always @(posedge clock) begin
        if (!rstn) begin
            status_r <= `SPIL_CTL8_RST;
            enable_r <= `SPIL_CTL8_RST;
            any_r <= 1'b0;
        end else begin
            status_r <= status_nxt;
            if (wr)
                enable_r <= wdata[15:`SPIL_EIS_EN_LSB];
            any_r <= |status_nxt;
        end
    end
endmodule

// >>> sim/spil_bus.sv
// two-wire bus with pull-ups and a second master issuing a start
`timescale 1ns/1ps
module spil_bus (
    // device pin drive
    input wire clk_o,
    input wire clk_oe_n,
    input wire dat_o,
    input wire dat_oe_n,
    // transfer request, wire levels, master state
    input wire go,
    output wire scl,
    output wire sda,
    output reg idle
);
    reg m_scl = 1'h1;
    reg m_sda = 1'h1;
    assign scl = m_scl & (clk_oe_n | clk_o);
    assign sda = m_sda & (dat_oe_n | dat_o);
    // start then 800 ns clocks; a held clock is waited out
    initial begin
        idle = 1'h1;
        forever begin
            @(posedge go);
            idle = 1'h0;
            m_sda = 1'h0;
            #400 m_scl = 1'h0;
            repeat (4) begin
                #400 m_scl = 1'h1;
                wait (scl === 1'h1);
                #400 m_scl = 1'h0;
            end
            #400 m_scl = 1'h1;
            #400 m_sda = 1'h1;
            idle = 1'h1;
        end
    end
endmodule

// >>> sim/spil_props.sv
// port checker for the serial port and interrupt logic
`timescale 1ns/1ps
`include "spil_defs.vh"
module spil_props (
    // clock, reset, access port
    input wire clock,
    input wire rstn,
    input wire acc_io,
    input wire [7:0] acc_addr,
    input wire acc_wr,
    input wire acc_rd,
    input wire [31:0] acc_wdata,
    input wire [31:0] acc_rdata,
    // pins, straps, events
    input wire serial_clock_pin_i,
    input wire serial_clock_pin_oe_n,
    input wire serial_data_pin_i,
    input wire serial_data_pin_oe_n,
    input wire port_address_strap,
    input wire alt_port_enable_strap,
    input wire vretrace_evt,
    input wire interrupt_pin_n
);
    wire io_hit = acc_io && !alt_port_enable_strap && acc_addr ==
        (port_address_strap ? `SPIL_IO_PORT_HI : `SPIL_IO_PORT_LO);
    wire spc = io_hit || (!acc_io && acc_addr == `SPIL_OFS_SPC);
    wire ms = acc_wr && !acc_io;
    wire sw = acc_wr && spc;
    wire [31:0] d = acc_wdata;
    reg [2:0] ctl_m;
    reg [7:0] ph;
    reg gie_m, arm_m, dis_m, enh_m, ie_m, str_m;
    wire drv = ctl_m[2] && !ctl_m[0];
    wire stab = ph[7:4] == {2{ph[1:0]}} && ph[3:2] == ph[1:0];
    // mirrors of written bits; pin history for live reads
    always @(posedge clock) begin
        ph <= {ph[5:0], serial_data_pin_i, serial_clock_pin_i};
        if (!rstn) begin
            ctl_m <= 3'h3;
            {gie_m, arm_m, dis_m, enh_m, ie_m, str_m} <= 6'h00;
        end else if (acc_wr) begin
            if (spc)
                ctl_m <= {d[4], d[1:0]};
            if (ms && acc_addr == `SPIL_OFS_GIE)
                gie_m <= d[4];
            if (ms && acc_addr == `SPIL_OFS_RTC)
                {dis_m, arm_m} <= d[5:4];
            if (ms && acc_addr == `SPIL_OFS_OPM)
                enh_m <= d[0];
            if (ms && acc_addr == `SPIL_OFS_VIC)
                {str_m, ie_m} <= {d[24], d[19]};
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    sequence s_retr;
        vretrace_evt && gie_m && arm_m && !dis_m && !enh_m;
    endsequence
    AST_OFF: assert property (sw && !d[4] |-> ##2 serial_data_pin_oe_n)
        else $error("data pin driven while disabled");
    AST_DLOW: assert property (sw && d[4] && !d[1] |-> ##2 !serial_data_pin_oe_n)
        else $error("data pin not pulled low");
    AST_CLOW: assert property (sw && d[4] && !d[0] |-> ##2 !serial_clock_pin_oe_n)
        else $error("clock pin not pulled low");
    AST_REL: assert property (sw && d[1] |-> ##2 serial_data_pin_oe_n)
        else $error("data pin not released");
    AST_LIVE: assert property (acc_rd && spc && stab |=> acc_rdata[3:2] == ph[3:2])
        else $error("pin levels misread");
    AST_HIT: assert property (acc_rd && io_hit |=> {acc_rdata[4], acc_rdata[1:0]} == ctl_m)
        else $error("port read wrong");
    AST_MISS: assert property (acc_rd && acc_io && !io_hit |=> acc_rdata == 32'h0)
        else $error("unselected port answered");
    AST_GIE: assert property (!gie_m && !$past(gie_m) |-> interrupt_pin_n)
        else $error("interrupt without global enable");
    AST_VGA: assert property (s_retr |-> ##2 !interrupt_pin_n)
        else $error("retrace interrupt missing");
    AST_CLR: assert property (ms && acc_addr == `SPIL_OFS_RTC && !d[4] && !enh_m && !ie_m |-> ##2 interrupt_pin_n)
        else $error("retrace interrupt not cleared");
    AST_STR: assert property ($fell(serial_clock_pin_oe_n) && !$past(drv) |-> str_m)
        else $error("clock held without stretch enable");
endmodule
bind spil_top spil_props u_props (.clock(clock), .rstn(rstn),
    .acc_io(acc_io), .acc_addr(acc_addr), .acc_wr(acc_wr), .acc_rd(acc_rd),
    .acc_wdata(acc_wdata), .acc_rdata(acc_rdata),
    .serial_clock_pin_i(serial_clock_pin_i),
    .serial_clock_pin_oe_n(serial_clock_pin_oe_n),
    .serial_data_pin_i(serial_data_pin_i),
    .serial_data_pin_oe_n(serial_data_pin_oe_n),
    .port_address_strap(port_address_strap),
    .alt_port_enable_strap(alt_port_enable_strap),
    .vretrace_evt(vretrace_evt), .interrupt_pin_n(interrupt_pin_n));

// >>> sim/tb_top.sv
// self-checking bench for the serial port and interrupt logic
`timescale 1ns/1ps
`include "spil_defs.vh"
module tb_top;
    reg clock = 1'h0;
    reg rstn = 1'h0;
    reg acc_io = 1'h0;
    reg [7:0] acc_addr = 8'h00;
    reg acc_wr = 1'h0;
    reg acc_rd = 1'h0;
    reg [31:0] acc_wdata = 32'h0;
    reg ps = 1'h1;
    reg as = 1'h1;
    reg vretrace_evt = 1'h0;
    reg [6:0] engine_evt = 7'h00;
    reg go = 1'h0;
    wire [31:0] acc_rdata;
    wire scl, sda, co, coe, dox, doe, irq_n, idle;
    integer mismatches = 0;
    integer samples_checked = 0;
    integer i, k;
    // 10 MHz system clock
    initial begin
        forever #50 clock = ~clock;
    end
    spil_top DUT (.clock(clock), .rstn(rstn), .acc_io(acc_io),
        .acc_addr(acc_addr), .acc_wr(acc_wr), .acc_rd(acc_rd),
        .acc_wdata(acc_wdata), .acc_rdata(acc_rdata),
        .serial_clock_pin_i(scl), .serial_clock_pin_o(co),
        .serial_clock_pin_oe_n(coe), .serial_data_pin_i(sda),
        .serial_data_pin_o(dox), .serial_data_pin_oe_n(doe),
        .port_address_strap(ps), .alt_port_enable_strap(as),
        .vretrace_evt(vretrace_evt), .engine_evt(engine_evt),
        .interrupt_pin_n(irq_n));
    spil_bus BUS (.clk_o(co), .clk_oe_n(coe), .dat_o(dox), .dat_oe_n(doe),
        .go(go), .scl(scl), .sda(sda), .idle(idle));
    task close_out;
        begin
            $display("mismatches %0d checked %0d", mismatches, samples_checked);
            if (mismatches == 0 && samples_checked > 0)
                $display("verification passed");
            else
                $display("verification failed");
            $finish;
        end
    endtask
    task cmp32(input [47:0] nm, input [31:0] e, input [31:0] g);
        begin
            samples_checked = samples_checked + 1;
            if (g !== e) begin
                mismatches = mismatches + 1;
                $display("CHECK FAILED %0s exp %h got %h", nm, e, g);
            end
        end
    endtask
    task cmp1(input [47:0] nm, input e, input g);
        cmp32(nm, {31'h0, e}, {31'h0, g});
    endtask
    task cyc(input integer n);
        repeat (n) @(negedge clock);
    endtask
    // one access, strobe held for one edge
    task acc(input io, input w, input [7:0] a, input [31:0] dv);
        begin
            @(negedge clock);
            acc_io = io;
            acc_addr = a;
            acc_wdata = dv;
            acc_wr = w;
            acc_rd = !w;
            @(negedge clock);
            acc_wr = 1'h0;
            acc_rd = 1'h0;
        end
    endtask
    task wr(input io, input [7:0] a, input [31:0] dv);
        acc(io, 1'h1, a, dv);
    endtask
    task rd(input io, input [7:0] a, input [31:0] e);
        begin
            acc(io, 1'h0, a, 32'h0);
            cmp32("rdata", e, acc_rdata);
        end
    endtask
    task rst(input a, input p);
        begin
            as = a;
            ps = p;
            rstn = 1'h0;
            cyc(12);
            rstn = 1'h1;
        end
    endtask
    task pulse(input [7:0] m);
        begin
            @(negedge clock);
            {engine_evt, vretrace_evt} = m;
            @(negedge clock);
            {engine_evt, vretrace_evt} = 8'h00;
            cyc(3);
        end
    endtask
    // bounded wait: interrupt low, or far master idle
    task wt(input sel);
        begin
            i = 0;
            while (!(sel ? idle === 1'h1 : irq_n === 1'h0) && i < 400) begin
                cyc(1);
                i = i + 1;
            end
            if (i == 400) begin
                mismatches = mismatches + 1;
                $display("CHECK FAILED wait exp %h got %h", sel,
                    sel ? idle : irq_n);
                close_out;
            end
        end
    endtask
    initial begin
        rst(1'h1, 1'h1);
        cmp1("clkoe", 1'h1, coe);
        rd(1'h0, `SPIL_OFS_SPC, 32'h0000_000f);
        rd(1'h0, 8'h44, 32'h0);
        rd(1'h1, 8'he2, 32'h0);
        wr(1'h0, `SPIL_OFS_SPC, 32'h0);
        cyc(2);
        cmp1("datoe", 1'h1, doe);
        wr(1'h0, `SPIL_OFS_SPC, 32'h10);
        cyc(4);
        rd(1'h0, `SPIL_OFS_SPC, 32'h0000_0010);
        wr(1'h0, `SPIL_OFS_SPC, 32'h12);
        cyc(4);
        rd(1'h0, `SPIL_OFS_SPC, 32'h0000_001a);
        rst(1'h0, 1'h1);
        rd(1'h1, 8'he2, 32'h0000_000f);
        rd(1'h1, 8'he8, 32'h0);
        rst(1'h0, 1'h0);
        wr(1'h1, 8'he8, 32'h10);
        cyc(4);
        rd(1'h0, `SPIL_OFS_SPC, 32'h0000_0010);
        wr(1'h1, 8'he8, 32'h13);
        // start from the far master, with stretch
        wr(1'h0, `SPIL_OFS_GIE, 32'h10);
        wr(1'h0, `SPIL_OFS_VIC, 32'h0108_0000);
        go = 1'h1;
        wt(1'h0);
        rd(1'h0, `SPIL_OFS_VIC, 32'h0108_0008);
        cmp1("clkoe", 1'h0, coe);
        wr(1'h0, `SPIL_OFS_VIC, 32'h0108_0008);
        cyc(3);
        cmp1("clkoe", 1'h1, coe);
        wt(1'h1);
        go = 1'h0;
        wr(1'h0, `SPIL_OFS_VIC, 32'h0);
        // retrace in VGA mode
        wr(1'h0, `SPIL_OFS_RTC, 32'h10);
        pulse(8'h01);
        cmp1("irq", 1'h0, irq_n);
        wr(1'h0, `SPIL_OFS_RTC, 32'h0);
        cyc(3);
        cmp1("irq", 1'h1, irq_n);
        pulse(8'h01);
        cmp1("irq", 1'h1, irq_n);
        wr(1'h0, `SPIL_OFS_GIE, 32'h0);
        wr(1'h0, `SPIL_OFS_RTC, 32'h10);
        pulse(8'h01);
        cmp1("irq", 1'h1, irq_n);
        wr(1'h0, `SPIL_OFS_RTC, 32'h30);
        wr(1'h0, `SPIL_OFS_GIE, 32'h10);
        wr(1'h0, `SPIL_OFS_EIS, 32'hff00);
        pulse(8'hff);
        cmp1("irq", 1'h1, irq_n);
        // enhanced mode, every source
        wr(1'h0, `SPIL_OFS_OPM, 32'h1);
        wr(1'h0, `SPIL_OFS_RTC, 32'h0);
        wr(1'h0, `SPIL_OFS_EIS, 32'hffff);
        for (k = 0; k < 8; k = k + 1) begin
            pulse(8'h01 << k);
            cmp1("irq", 1'h0, irq_n);
            rd(1'h0, `SPIL_OFS_EIS, 32'hff00 | (32'h1 << k));
            wr(1'h0, `SPIL_OFS_EIS, 32'hff00 | (32'h1 << k));
            cyc(3);
            cmp1("irq", 1'h1, irq_n);
        end
        pulse(8'h81);
        wr(1'h0, `SPIL_OFS_EIS, 32'hff01);
        cyc(3);
        cmp1("irq", 1'h0, irq_n);
        wr(1'h0, `SPIL_OFS_EIS, 32'hff80);
        cyc(3);
        cmp1("irq", 1'h1, irq_n);
        wr(1'h0, `SPIL_OFS_EIS, 32'h0800);
        pulse(8'h02);
        cmp1("irq", 1'h1, irq_n);
        close_out;
    end
endmodule
